// *** verilog/dtp_timer_pair.v ***
`timescale 1ns/1ps
`include "dtp_map.vh"

// =====================================================================
// Dual 8-bit timer / PWM unit with APB register access
module dtp_timer_pair (
  input  wire        i_clk,
  input  wire        i_rst,
  input  wire        i_psel,
  input  wire        i_penable,
  input  wire        i_pwrite,
  input  wire [7:0]  i_paddr,
  input  wire [31:0] i_pwdata,
  output reg  [31:0] o_prdata,
  output wire        o_pready,
  output wire        o_pslverr,
  input  wire        i_ext_clk,
  output wire        o_timer_pwm_out_pin
);

  // ===================================================================
  // Taps: 0 div1, 1 div4, 2 div16, 3 div256
  wire [3:0] tap;

  dtp_prescaler dtp_prescaler_i (
    .i_clk (i_clk),
    .i_rst (i_rst),
    .o_tap (tap)
  );

  // ===================================================================
  // Registers
  reg  [2:0]  run_q;
  reg  [7:0]  timer_pair_mode_reg_q;
  reg  [7:0]  lower_compare_reg_q;
  reg  [7:0]  lower_cmp_buf_q;
  reg  [7:0]  upper_compare_reg_q;
  reg  [1:0]  out_ff_ctrl_reg_q;
  reg  [1:0]  port_q;
  reg         output_flip_flop_q;
  reg  [7:0]  lower_up_counter_q;
  reg  [7:0]  upper_cnt_q;
  reg  [2:0]  ext_sync_q;
  reg         ext_lvl_q;

  wire [1:0]  pair_mode_sel;
  wire [1:0]  pwm_cycle_sel;
  wire [1:0]  upper_clk_sel;
  wire [1:0]  lower_clk_sel;
  wire        out_ff_src_sel;
  wire        inv_en;
  wire        dbuf_en;
  wire        lower_run;
  wire        upper_run;

  assign pair_mode_sel  = timer_pair_mode_reg_q[`DTP_MODE_PAIR];
  assign pwm_cycle_sel  = timer_pair_mode_reg_q[`DTP_MODE_PWM];
  assign upper_clk_sel  = timer_pair_mode_reg_q[`DTP_MODE_UCLK];
  assign lower_clk_sel  = timer_pair_mode_reg_q[`DTP_MODE_LCLK];
  assign out_ff_src_sel = out_ff_ctrl_reg_q[`DTP_FF_SRC];
  assign inv_en         = out_ff_ctrl_reg_q[`DTP_FF_INV];
  assign dbuf_en        = run_q[`DTP_RUN_DBUF];
  assign lower_run      = run_q[`DTP_RUN_LOWER];
  assign upper_run      = run_q[`DTP_RUN_UPPER];

  // ===================================================================
  // APB decode
  wire wr_en;
  wire setup;
  wire mapped;

  assign wr_en  = i_psel & i_penable & i_pwrite;
  assign setup  = i_psel & ~i_penable;
  assign mapped = (i_paddr == `DTP_OFS_RUN)  | (i_paddr == `DTP_OFS_MODE) |
                  (i_paddr == `DTP_OFS_LCMP) | (i_paddr == `DTP_OFS_UCMP) |
                  (i_paddr == `DTP_OFS_FFCR) | (i_paddr == `DTP_OFS_PORT) |
                  (i_paddr == `DTP_OFS_STAT);

  assign o_pready  = 1'b1;
  assign o_pslverr = i_psel & i_penable & ~mapped;

  wire wr_run;
  wire wr_mode;
  wire wr_lcmp;
  wire wr_ucmp;
  wire wr_ffcr;
  wire wr_port;

  assign wr_run  = wr_en & (i_paddr == `DTP_OFS_RUN);
  assign wr_mode = wr_en & (i_paddr == `DTP_OFS_MODE);
  assign wr_lcmp = wr_en & (i_paddr == `DTP_OFS_LCMP);
  assign wr_ucmp = wr_en & (i_paddr == `DTP_OFS_UCMP);
  assign wr_ffcr = wr_en & (i_paddr == `DTP_OFS_FFCR);
  assign wr_port = wr_en & (i_paddr == `DTP_OFS_PORT);

  // Read data captured in the setup cycle, valid in the access cycle
  reg [31:0] rd_d;

  always @* begin
    rd_d = 32'h0000_0000;
    case (i_paddr)
      `DTP_OFS_RUN:  rd_d = {29'h0000_0000, run_q};
      `DTP_OFS_MODE: rd_d = {24'h00_0000, timer_pair_mode_reg_q};
      `DTP_OFS_LCMP: rd_d = {24'h00_0000, lower_compare_reg_q};
      `DTP_OFS_UCMP: rd_d = {24'h00_0000, upper_compare_reg_q};
      `DTP_OFS_FFCR: rd_d = {28'h000_0000, `DTP_FFC_READ, out_ff_ctrl_reg_q};
      `DTP_OFS_PORT: rd_d = {30'h0000_0000, port_q};
      `DTP_OFS_STAT: rd_d = {15'h0000, output_flip_flop_q, upper_cnt_q,
                             lower_up_counter_q};
      default:       rd_d = 32'h0000_0000;
    endcase
  end

  always @(posedge i_clk) begin
    if (i_rst) begin
      o_prdata <= 32'h0000_0000;
    end else if (setup) begin
      o_prdata <= rd_d;
    end
  end

  // ===================================================================
  // Control registers
  always @(posedge i_clk) begin
    if (i_rst) begin
      run_q                 <= `DTP_RST_RUN;
      timer_pair_mode_reg_q <= `DTP_RST_MODE;
      upper_compare_reg_q   <= `DTP_RST_CMP;
      out_ff_ctrl_reg_q     <= `DTP_RST_FFCR;
      port_q                <= `DTP_RST_PORT;
    end else begin
      if (wr_run) begin
        run_q <= i_pwdata[2:0];
      end
      if (wr_mode) begin
        timer_pair_mode_reg_q <= i_pwdata[7:0];
      end
      if (wr_ucmp) begin
        upper_compare_reg_q <= i_pwdata[7:0];
      end
      if (wr_ffcr) begin
        out_ff_ctrl_reg_q <= i_pwdata[1:0];
      end
      if (wr_port) begin
        port_q <= i_pwdata[1:0];
      end
    end
  end

  // ===================================================================
  // External clock pin: three stages, edge once stages two and three agree
  always @(posedge i_clk) begin
    if (i_rst) begin
      ext_sync_q <= 3'h0;
      ext_lvl_q  <= 1'b0;
    end else begin
      ext_sync_q <= {ext_sync_q[1:0], i_ext_clk};
      if (ext_sync_q[1] == ext_sync_q[2]) begin
        ext_lvl_q <= ext_sync_q[2];
      end
    end
  end

  wire ext_rise;
  assign ext_rise = (ext_sync_q[1] == ext_sync_q[2]) & ext_sync_q[2] & ~ext_lvl_q;

  // ===================================================================
  // Clock selection
  reg  tick0;
  reg  tick1;
  reg  [7:0] ovf_val;
  wire lower_match;

  always @* begin
    case (lower_clk_sel)
      2'b00:   tick0 = ext_rise;
      2'b01:   tick0 = tap[0];
      2'b10:   tick0 = tap[1];
      default: tick0 = tap[2];
    endcase
  end

  always @* begin
    case (upper_clk_sel)
      2'b00:   tick1 = (pair_mode_sel == `DTP_PAIR_DUAL) & lower_match;
      2'b01:   tick1 = tap[0];
      2'b10:   tick1 = tap[2];
      default: tick1 = tap[3];
    endcase
  end

  always @* begin
    case (pwm_cycle_sel)
      2'b01:   ovf_val = `DTP_OVF_6;
      2'b10:   ovf_val = `DTP_OVF_7;
      default: ovf_val = `DTP_OVF_8;
    endcase
  end

  // ===================================================================
  // Event detection on the value a tick would produce
  wire        mode_dual;
  wire        mode_casc;
  wire        mode_ppg;
  wire        mode_pwm;
  wire        step0;
  wire        step1;
  wire [7:0]  next0;
  wire [7:0]  next1;
  wire [15:0] next16;
  wire        casc_match;
  wire        ppg_period;
  wire        pwm_ovf;
  wire        upper_match;

  assign mode_dual = (pair_mode_sel == `DTP_PAIR_DUAL);
  assign mode_casc = (pair_mode_sel == `DTP_PAIR_CASC);
  assign mode_ppg  = (pair_mode_sel == `DTP_PAIR_PPG);
  assign mode_pwm  = (pair_mode_sel == `DTP_PAIR_PWM);

  assign step0  = lower_run & tick0;
  assign step1  = upper_run & tick1;
  assign next0  = lower_up_counter_q + 8'h01;
  assign next1  = upper_cnt_q + 8'h01;
  assign next16 = {upper_cnt_q, lower_up_counter_q} + 16'h0001;

  assign lower_match = step0 & (next0 == lower_compare_reg_q);
  assign casc_match  = mode_casc & step0 & upper_run &
                       (next16 == {upper_compare_reg_q, lower_compare_reg_q});
  assign ppg_period  = mode_ppg & step0 & (next0 == upper_compare_reg_q);
  assign pwm_ovf     = mode_pwm & step0 & (next0 == ovf_val);
  assign upper_match = step1 & (mode_dual | mode_pwm) & (next1 == upper_compare_reg_q);

  // ===================================================================
  // Lower up-counter
  always @(posedge i_clk) begin
    if (i_rst) begin
      lower_up_counter_q <= 8'h00;
    end else if (!lower_run) begin
      lower_up_counter_q <= 8'h00;
    end else if (step0) begin
      if (mode_casc) begin
        lower_up_counter_q <= casc_match ? 8'h00 : next16[7:0];
      end else if (mode_pwm) begin
        lower_up_counter_q <= pwm_ovf ? 8'h00 : next0;
      end else if (mode_ppg) begin
        lower_up_counter_q <= ppg_period ? 8'h00 : next0;
      end else begin
        lower_up_counter_q <= lower_match ? 8'h00 : next0;
      end
    end
  end

  // ===================================================================
  // Upper up-counter, independent in PWM mode
  always @(posedge i_clk) begin
    if (i_rst) begin
      upper_cnt_q <= 8'h00;
    end else if (!upper_run || mode_ppg) begin
      upper_cnt_q <= 8'h00;
    end else if (mode_casc) begin
      if (casc_match) begin
        upper_cnt_q <= 8'h00;
      end else if (step0) begin
        upper_cnt_q <= next16[15:8];
      end
    end else if (step1) begin
      upper_cnt_q <= upper_match ? 8'h00 : next1;
    end
  end

  // ===================================================================
  // Lower compare register with optional double buffer
  wire buf_load;
  assign buf_load = dbuf_en & (pwm_ovf | ppg_period);

  always @(posedge i_clk) begin
    if (i_rst) begin
      lower_compare_reg_q <= `DTP_RST_CMP;
      lower_cmp_buf_q     <= `DTP_RST_CMP;
    end else begin
      if (wr_lcmp) begin
        lower_cmp_buf_q <= i_pwdata[7:0];
      end
      if (wr_lcmp && !dbuf_en) begin
        lower_compare_reg_q <= i_pwdata[7:0];
      end else if (buf_load) begin
        lower_compare_reg_q <= lower_cmp_buf_q;
      end
    end
  end

  // ===================================================================
  // Output flip-flop
  reg ff_toggle;

  always @* begin
    case (pair_mode_sel)
      `DTP_PAIR_DUAL: ff_toggle = inv_en &
                                  (out_ff_src_sel ? upper_match : lower_match);
      `DTP_PAIR_CASC: ff_toggle = inv_en & casc_match;
      `DTP_PAIR_PPG:  ff_toggle = inv_en & (lower_match | ppg_period);
      default:        ff_toggle = lower_match ^ pwm_ovf;
    endcase
  end

  always @(posedge i_clk) begin
    if (i_rst) begin
      output_flip_flop_q <= 1'b0;
    end else if (wr_ffcr && i_pwdata[`DTP_FF_CTRL] == `DTP_FFC_INVERT) begin
      output_flip_flop_q <= ~output_flip_flop_q;
    end else if (wr_ffcr && i_pwdata[`DTP_FF_CTRL] == `DTP_FFC_SET) begin
      output_flip_flop_q <= 1'b1;
    end else if (wr_ffcr && i_pwdata[`DTP_FF_CTRL] == `DTP_FFC_CLEAR) begin
      output_flip_flop_q <= 1'b0;
    end else if (ff_toggle) begin
      output_flip_flop_q <= ~output_flip_flop_q;
    end
  end

  // ===================================================================
  // Shared port line: timer output or general-purpose data
  assign o_timer_pwm_out_pin = port_q[`DTP_PORT_FUNC] ? output_flip_flop_q
                                                       : port_q[`DTP_PORT_DATA];

endmodule // dtp_timer_pair

// *** verilog/dtp_map.vh ***
`ifndef DTP_MAP_VH
`define DTP_MAP_VH

// =====================================================================
// Register byte offsets
`define DTP_OFS_RUN      8'h00
`define DTP_OFS_MODE     8'h04
`define DTP_OFS_LCMP     8'h08
`define DTP_OFS_UCMP     8'h0c
`define DTP_OFS_FFCR     8'h10
`define DTP_OFS_PORT     8'h14
`define DTP_OFS_STAT     8'h18

// =====================================================================
// Field positions
`define DTP_RUN_LOWER    0
`define DTP_RUN_UPPER    1
`define DTP_RUN_DBUF     2
`define DTP_MODE_PAIR    7:6
`define DTP_MODE_PWM     5:4
`define DTP_MODE_UCLK    3:2
`define DTP_MODE_LCLK    1:0
`define DTP_FF_CTRL      3:2
`define DTP_FF_INV       1
`define DTP_FF_SRC       0
`define DTP_PORT_FUNC    0
`define DTP_PORT_DATA    1

// =====================================================================
// Encodings
`define DTP_PAIR_DUAL    2'b00
`define DTP_PAIR_CASC    2'b01
`define DTP_PAIR_PPG     2'b10
`define DTP_PAIR_PWM     2'b11
`define DTP_FFC_INVERT   2'b00
`define DTP_FFC_SET      2'b01
`define DTP_FFC_CLEAR    2'b10
`define DTP_FFC_READ     2'b11
`define DTP_OVF_6        8'h3f
`define DTP_OVF_7        8'h7f
`define DTP_OVF_8        8'hff

// =====================================================================
// Reset values
`define DTP_RST_RUN      3'h0
`define DTP_RST_MODE     8'h00
`define DTP_RST_CMP      8'h00
`define DTP_RST_FFCR     2'h0
`define DTP_RST_PORT     2'h0

// =====================================================================
// Prescaler tap masks, one less than the divide ratio in clock cycles
`define DTP_PRE_WIDTH    8
`define DTP_TAP_DIV4     8'h03
`define DTP_TAP_DIV16    8'h0f
`define DTP_TAP_DIV256   8'hff

`endif

// *** verilog/dtp_prescaler.v ***
`timescale 1ns/1ps
`include "dtp_map.vh"

// =====================================================================
// Free-running prescaler with one-cycle tap enables
module dtp_prescaler (
  input  wire       i_clk,
  input  wire       i_rst,
  output wire [3:0] o_tap
);

  reg  [`DTP_PRE_WIDTH-1:0] cnt_q;
  wire [`DTP_PRE_WIDTH-1:0] mask [0:3];

  assign mask[0] = 8'h00;
  assign mask[1] = `DTP_TAP_DIV4;
  assign mask[2] = `DTP_TAP_DIV16;
  assign mask[3] = `DTP_TAP_DIV256;

  always @(posedge i_clk) begin
    if (i_rst) begin
      cnt_q <= 8'h00;
    end else begin
      cnt_q <= cnt_q + 8'h01;
    end
  end

  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1) begin : g_tap
      assign o_tap[g] = ((cnt_q & mask[g]) == mask[g]);
    end
  endgenerate

endmodule // dtp_prescaler

// *** bench/dtp_timer_pair_properties.sv ***
`timescale 1ns/1ps
// ====================
// Port-level checks
module dtp_timer_pair_properties (
  input wire        i_clk,
  input wire        i_rst,
  input wire        i_psel,
  input wire        i_penable,
  input wire        i_pwrite,
  input wire [7:0]  i_paddr,
  input wire [31:0] i_pwdata,
  input wire [31:0] o_prdata,
  input wire        o_pready,
  input wire        o_pslverr,
  input wire        i_ext_clk,
  input wire        o_timer_pwm_out_pin
);
  reg  [7:0]  run_q, mode_q, lcmp_q, ucmp_q;
  reg  [1:0]  port_q, nedge_q;
  reg         src_q, pin_q;
  reg  [15:0] cnt_q, prev_q;
  wire        p    = o_timer_pwm_out_pin;
  wire        wr   = i_psel & i_penable & i_pwrite;
  wire        chg  = p != pin_q;
  wire        ok   = run_q[0] & port_q[0] & chg & (nedge_q == 2'h3);
  wire [1:0]  pm   = mode_q[7:6];
  wire [1:0]  lc   = mode_q[1:0];
  wire        pwm  = ok & (pm == 2'h3) & (lc != 2'h0);
  wire        ppg  = ok & (pm == 2'h2) & (lc == 2'h1);
  wire        dual = ok & (pm == 2'h0) & (src_q ? mode_q[3:2] == 2'h1 : lc == 2'h1);
  wire [15:0] div  = lc == 2'h1 ? 16'h1 : lc == 2'h2 ? 16'h4 : 16'h10;
  wire [15:0] ovf  = mode_q[5:4] == 2'h1 ? 16'h3f : mode_q[5:4] == 2'h2 ? 16'h7f : 16'hff;

  // Interval between pin changes, checked only after config settles
  always @(posedge i_clk) begin
    pin_q <= p;
    cnt_q <= chg ? 16'h1 : cnt_q + 16'h1;
    if (chg)
      prev_q <= cnt_q;
    if (i_rst | wr)
      nedge_q <= 2'h0;
    else if (chg & (nedge_q != 2'h3))
      nedge_q <= nedge_q + 2'h1;
    if (i_rst) begin
      run_q  <= 8'h0;
      port_q <= 2'h0;
    end else if (wr) begin
      case (i_paddr)
        8'h00: run_q <= i_pwdata[7:0];
        8'h04: mode_q <= i_pwdata[7:0];
        8'h08: lcmp_q <= i_pwdata[7:0];
        8'h0c: ucmp_q <= i_pwdata[7:0];
        8'h10: src_q <= i_pwdata[0];
        8'h14: port_q <= i_pwdata[1:0];
        default: ;
      endcase
    end
  end

  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (i_rst);

  property p_gpio;
    !port_q[0] |-> p == port_q[1];
  endproperty
  a_gpio: assert property (p_gpio) else $error("pin not port data");
  property p_stop;
    run_q[1:0] == 2'h0 && !$past(wr) |-> $stable(p);
  endproperty
  a_stop: assert property (p_stop) else $error("pin moved while stopped");
  property p_upper;
    !run_q[0] && pm == 2'h3 && !$past(wr) |-> $stable(p);
  endproperty
  a_upper: assert property (p_upper) else $error("upper timer moved pin");
  property p_match;
    pwm |-> cnt_q == div * lcmp_q || cnt_q == div * (ovf - lcmp_q);
  endproperty
  a_match: assert property (p_match) else $error("pwm edge off");
  property p_period;
    pwm |-> prev_q + cnt_q == div * ovf;
  endproperty
  a_period: assert property (p_period) else $error("pwm period off");
  property p_dual;
    dual |-> cnt_q == (src_q ? ucmp_q : lcmp_q);
  endproperty
  a_dual: assert property (p_dual) else $error("toggle source off");
  property p_ppg;
    ppg |-> prev_q + cnt_q == ucmp_q;
  endproperty
  a_ppg: assert property (p_ppg) else $error("pulse period off");
  property p_err;
    i_psel && i_penable |-> o_pslverr == !(i_paddr[1:0] == 2'h0 && i_paddr <= 8'h18);
  endproperty
  a_err: assert property (p_err) else $error("slave error wrong");
endmodule // dtp_timer_pair_properties

bind dtp_timer_pair dtp_timer_pair_properties dtp_timer_pair_properties_i (
  .i_clk(i_clk), .i_rst(i_rst), .i_psel(i_psel), .i_penable(i_penable),
  .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata), .o_prdata(o_prdata),
  .o_pready(o_pready), .o_pslverr(o_pslverr), .i_ext_clk(i_ext_clk),
  .o_timer_pwm_out_pin(o_timer_pwm_out_pin)
);

// *** bench/dtp_timer_pair_test.sv ***
`timescale 1ns/1ps
// ====================
// Self-checking bench
module dtp_timer_pair_test;
  reg         i_clk, i_rst, i_psel, i_penable, i_pwrite, i_ext_clk, err;
  reg  [7:0]  i_paddr;
  reg  [31:0] i_pwdata, rd;
  wire [31:0] o_prdata;
  wire        o_pready, o_pslverr, pin;
  integer     miscompares, n_tests;

  dtp_timer_pair dtp_timer_pair_i (
    .i_clk(i_clk), .i_rst(i_rst), .i_psel(i_psel), .i_penable(i_penable),
    .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata), .o_prdata(o_prdata),
    .o_pready(o_pready), .o_pslverr(o_pslverr), .i_ext_clk(i_ext_clk),
    .o_timer_pwm_out_pin(pin)
  );

  initial begin
    i_clk = 1'b0;
    forever #2.5 i_clk = ~i_clk;
  end
  // External count pin at a quarter of the clock, slow enough for the synchroniser
  reg         ext_ph;
  always @(posedge i_clk) begin
    ext_ph <= ~ext_ph;
    if (ext_ph)
      i_ext_clk <= ~i_ext_clk;
  end

  // ====================
  // Compare and bus tasks
  task chk_word(input [31:0] got, input [31:0] exp);
    n_tests = n_tests + 1;
    if (got !== exp) begin
      miscompares = miscompares + 1;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task chk_span(input integer got, input integer exp);
    n_tests = n_tests + 1;
    if (got !== exp) begin
      miscompares = miscompares + 1;
      $display("unexpected at %0t: span %0d want %0d", $time, got, exp);
    end
  endtask
  task apb(input wr, input [7:0] a, input [31:0] wd);
    @(posedge i_clk);
    i_psel   <= 1'b1;
    i_pwrite <= wr;
    i_paddr  <= a;
    i_pwdata <= wd;
    @(posedge i_clk);
    i_penable <= 1'b1;
    do @(posedge i_clk); while (o_pready !== 1'b1);
    rd = o_prdata;
    err = o_pslverr;
    i_psel    <= 1'b0;
    i_penable <= 1'b0;
  endtask
  task w(input [7:0] a, input [31:0] d);
    apb(1'b1, a, d);
  endtask
  task r(input [7:0] a);
    apb(1'b0, a, 32'h0);
  endtask
  task span(output integer d);
    reg s;
    s = pin;
    d = 0;
    do begin
      @(negedge i_clk);
      d = d + 1;
    end while (pin === s && d < 4000);
  endtask

  // ====================
  // Scenarios
  task test_reset;
    reg [7:0] a;
    for (a = 8'h00; a < 8'h20; a = a + 8'h04) begin
      r(a);
      chk_word(rd, a == 8'h10 ? 32'hc : 32'h0);
      chk_word({31'h0, err}, a == 8'h1c ? 32'h1 : 32'h0);
    end
  endtask
  task test_port;
    w(8'h14, 32'h2);
    @(negedge i_clk);
    chk_word({31'h0, pin}, 32'h1);
    w(8'h14, 32'h0);
    @(negedge i_clk);
    chk_word({31'h0, pin}, 32'h0);
  endtask
  task run_case(input [7:0] m, l, u, f, input integer ea, eb);
    integer a, b, t;
    w(8'h00, 32'h0);
    w(8'h04, {24'h0, m});
    w(8'h08, {24'h0, l});
    w(8'h0c, {24'h0, u});
    w(8'h10, {24'h0, f});
    w(8'h14, 32'h1);
    w(8'h00, 32'h3);
    span(a);
    span(a);
    span(a);
    span(b);
    if (a !== ea) begin
      t = a;
      a = b;
      b = t;
    end
    chk_span(a, ea);
    chk_span(b, eb);
  endtask
  task test_modes;
    run_case(8'h05, 8'h03, 8'hff, 8'h0a, 3, 3);
    run_case(8'h05, 8'h03, 8'h0a, 8'h0b, 10, 10);
    run_case(8'h01, 8'h04, 8'h03, 8'h0b, 12, 12);
    run_case(8'h09, 8'hff, 8'h02, 8'h0b, 32, 32);
    run_case(8'h0d, 8'hff, 8'h01, 8'h0b, 256, 256);
    run_case(8'h45, 8'h02, 8'h01, 8'h0a, 258, 258);
    run_case(8'h85, 8'h05, 8'h0c, 8'h0a, 5, 7);
    run_case(8'hd5, 8'h20, 8'hff, 8'h0a, 32, 31);
    run_case(8'he5, 8'h48, 8'hff, 8'h0a, 72, 55);
    run_case(8'hf5, 8'h20, 8'hff, 8'h0a, 32, 223);
    run_case(8'hd6, 8'h20, 8'hff, 8'h0a, 128, 124);
    run_case(8'hd7, 8'h20, 8'hff, 8'h0a, 512, 496);
    run_case(8'hd4, 8'h20, 8'hff, 8'h0a, 128, 124);
  endtask
  task test_dbuf;
    integer a;
    w(8'h00, 32'h0);
    w(8'h04, 32'hd5);
    w(8'h08, 32'h20);
    w(8'h00, 32'h4);
    w(8'h08, 32'h10);
    r(8'h08);
    chk_word(rd, 32'h20);
    w(8'h00, 32'h5);
    span(a);
    span(a);
    span(a);
    chk_span(a, 16);
    span(a);
    chk_span(a, 47);
  endtask
  task test_upper;
    reg [31:0] t;
    w(8'h00, 32'h0);
    w(8'h0c, 32'hff);
    r(8'h18);
    chk_word(rd, 32'h0);
    w(8'h00, 32'h2);
    r(8'h18);
    t = rd;
    r(8'h18);
    chk_word({24'h0, rd[15:8] - t[15:8]}, 32'h3);
    chk_word({24'h0, rd[7:0]}, 32'h0);
  endtask
  task test_ffcr;
    w(8'h00, 32'h0);
    w(8'h10, 32'h4);
    r(8'h18);
    chk_word(rd, 32'h0001_0000);
    w(8'h10, 32'hc);
    @(negedge i_clk);
    chk_word({31'h0, pin}, 32'h1);
    w(8'h10, 32'h0);
    r(8'h18);
    chk_word(rd, 32'h0);
  endtask

  task print_verdict;
    $display("comparisons %0d, miscompares %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  initial begin
    i_rst = 1'b1;
    i_psel = 1'b0;
    i_penable = 1'b0;
    i_pwrite = 1'b0;
    i_paddr = 8'h0;
    i_pwdata = 32'h0;
    i_ext_clk = 1'b0;
    ext_ph = 1'b0;
    miscompares = 0;
    n_tests = 0;
    repeat (8) @(posedge i_clk);
    i_rst <= 1'b0;
    test_reset;
    test_port;
    test_modes;
    test_dbuf;
    test_upper;
    test_ffcr;
    print_verdict;
  end
  initial begin
    #100000;
    miscompares = miscompares + 1;
    $display("unexpected at %0t: watchdog expired", $time);
    print_verdict;
  end
endmodule // dtp_timer_pair_test
